// file: include/ufc_pkg.sv
// Purpose: shared constants, types and tables for the uart control block
// Assumes: 8-bit host register bus, one 25 MHz clock
// Notes: divisor counts clock cycles per half bit time
package ufc_pkg;
	// register offsets on the 4-bit host address
	localparam logic [3:0] ADDR_DATA = 4'h0;
	localparam logic [3:0] ADDR_HIGH = 4'h1;
	localparam logic [3:0] ADDR_FIFO = 4'h2;
	localparam logic [3:0] ADDR_LINE = 4'h3;
	localparam logic [3:0] ADDR_MODEM = 4'h4;
	localparam logic [3:0] ADDR_FEAT = 4'h8;
	localparam logic [3:0] ADDR_ENH = 4'h9;
	localparam logic [3:0] ADDR_TX_TRIGGER_LEVEL_REG = 4'ha;
	localparam logic [3:0] ADDR_RX_TRIGGER_LEVEL_REG = 4'hb;
	localparam logic [3:0] ADDR_STAT = 4'hc;
	localparam logic [3:0] ADDR_LEVEL = 4'hd;

	// field positions
	localparam int FCR_EN = 0;
	localparam int FCR_TXCLR = 2;
	localparam int FCR_DMA = 3;
	localparam int FEATURE_CONTROL_IRINV = 4;
	localparam int EFR_SWFLOW = 3;
	localparam int EFR_ARTS = 6;
	localparam int EFR_ACTS = 7;
	localparam logic [7:0] MODEM_WMASK = 8'hf7;

	// reset values
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] TRG_RST = 8'h01;
	localparam logic [7:0] DIV_LO_RST = 8'h01;
	localparam logic [3:0] PIN_IDLE = 4'h7;
	localparam logic OUT_IDLE = 1'b1;
	localparam logic [5:0] ISR_NONE = 6'h01;

	// counts
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	localparam logic [2:0] HALF_BIT = 3'h2;
	localparam logic [2:0] STOP_H1 = 3'h2;
	localparam logic [2:0] STOP_H15 = 3'h3;
	localparam logic [2:0] STOP_H2 = 3'h4;
	localparam int FIFO_D = 4;
	localparam int CNT_W = 3;

	// flow characters
	localparam logic [7:0] XON_CHAR = 8'h11;
	localparam logic [7:0] XOFF_CHAR = 8'h13;

	// trigger tables, index is the fifo_control field
	localparam logic [1:0] TBL_B = 2'h1;
	localparam logic [1:0] TBL_C = 2'h2;
	localparam logic [1:0] TBL_D = 2'h3;
	localparam logic [7:0] RX_TRIG_A [4] = '{8'h01, 8'h04, 8'h08, 8'h0e};
	localparam logic [7:0] TX_TRIG_A = 8'h01;
	localparam logic [7:0] RX_TRIG_B [4] = '{8'h08, 8'h10, 8'h18, 8'h1c};
	localparam logic [7:0] TX_TRIG_B [4] = '{8'h10, 8'h08, 8'h18, 8'h1e};
	localparam logic [7:0] RX_TRIG_C [4] = '{8'h08, 8'h10, 8'h38, 8'h3c};
	localparam logic [7:0] TX_TRIG_C [4] = '{8'h08, 8'h10, 8'h20, 8'h38};

	typedef struct packed {
		logic dlab;
		logic brk;
		logic force_par;
		logic even;
		logic pen;
		logic stop;
		logic [1:0] wlen;
	} ufc_line_s;

	typedef struct packed {
		logic presc;
		logic ir_en;
		logic xon_any;
		logic loop_en;
		logic rsvd;
		logic pair_sel;
		logic rts;
		logic dtr;
	} ufc_modem_s;

	typedef struct packed {
		logic ferr;
		logic perr;
		logic [7:0] data;
	} ufc_char_s;

	typedef enum logic [2:0] {
		BIT_IDLE = 3'h0,
		BIT_START = 3'h1,
		BIT_DATA = 3'h3,
		BIT_PAR = 3'h2,
		BIT_STOP = 3'h6
	} ufc_bit_e;
endpackage

// file: design/ufc_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: D is a power of two
// Notes: clr_i empties the fifo without touching stored words
`timescale 1ns/1ps
module ufc_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic clr_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o,
	output logic [$clog2(D+1)-1:0] count_o
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D + 1);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [CW-1:0] cnt_reg;
	wire push = in_valid_i & in_ready_o;
	wire pop = out_valid_o & out_ready_i;

	assign in_ready_o = cnt_reg != CW'(D);
	assign out_valid_o = cnt_reg != '0;
	assign out_data_o = mem[rd_ptr_reg];
	assign count_o = cnt_reg;

	always_ff @(posedge mclk_i) begin
		if (push)
			mem[wr_ptr_reg] <= in_data_i;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
		end else if (clr_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
		end
	end
endmodule

// file: design/ufc_core.sv
// Purpose: one uart channel: fifo control, character format, modem lines
// Assumes: host strobes are one-cycle pulses in the mclk_i domain
// Notes: tx/rx fifos are 4 deep, so deep trigger levels never trip
//
// What this block does
// - tx fifo reset bit empties tx fifo, not the shifter; self clears.
// - fifo_control bit 3 dma mode is stored and only shows in status bit 7.
// - tx irq when level drops below trigger, or at empty if never above.
// - rx interrupt when rx level reaches the selected rx trigger.
// - one trigger table shared by rx and tx, last selection wins.
// - table A gives rx 1,4,8,14 and tx fixed at 1.
// - table B gives rx 8,16,24,28 and tx 16,8,24,30.
// - table C gives rx 8,16,56,60 and tx 8,16,32,56.
// - feature_control 7:6 picks table; table D uses trigger registers.
// - line_format_control 1:0 sets 5,6,7 or 8 data bits both ways.
// - stop select gives 1, or 1.5 for 5 bits and 2 otherwise.
// - parity enable adds parity on transmit and checks it on receive.
// - even select 0 means odd parity, 1 means even parity.
// - forced parity sends and expects the inverse of even select.
// - break bit holds the transmit line at space until cleared.
// - line_format_control bit 7 maps data addresses onto divisor latches.
// - dtr and rts bits drive their pins inverted, both reset high.
// - auto flow enable uses pair select: rts/cts at 0, dtr/dsr at 1.
// - loopback bit turns transmit back into receive internally, off at reset.
// - xon-any lets any received character other than xoff resume a halted transmitter.
// - infrared enable loads from the select pin after reset release.
// - infrared mode encodes tx, idles low, may invert rx before decode.
`timescale 1ns/1ps
module ufc_core
	import ufc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [3:0] bus_addr_i,
	input wire logic [7:0] bus_wdata_i,
	output logic [7:0] bus_rdata_o,
	input wire logic rx_i,
	input wire logic cts_n_i,
	input wire logic dsr_n_i,
	input wire logic infrared_select_pin_i,
	output logic tx_o,
	output logic dtr_n_o,
	output logic rts_n_o,
	output logic tx_irq_o,
	output logic rx_irq_o
);
	// pin synchronisers: a change counts once stages two and three agree
	logic [3:0] pin_raw;
	logic [3:0] pin_s1_reg;
	logic [3:0] pin_s2_reg;
	logic [3:0] pin_s3_reg;
	logic [3:0] pin_f_reg;
	wire [3:0] pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
	wire [3:0] pin_f_nx = (pin_f_reg & ~pin_agree) | (pin_s3_reg & pin_agree);
	assign pin_raw = {infrared_select_pin_i, dsr_n_i, cts_n_i, rx_i};

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1_reg <= PIN_IDLE;
			pin_s2_reg <= PIN_IDLE;
			pin_s3_reg <= PIN_IDLE;
			pin_f_reg <= PIN_IDLE;
		end else begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_f_reg <= pin_f_nx;
		end
	end

	// register state
	ufc_line_s line_reg;
	ufc_modem_s modem_reg;
	logic [7:0] feat_reg;
	logic [7:0] enh_reg;
	logic [7:0] tx_trigger_level_reg_reg;
	logic [7:0] rx_trigger_level_reg_reg;
	logic [7:0] div_lo_reg;
	logic [7:0] div_hi_reg;
	logic fifo_en_reg;
	logic dma_mode_reg;
	logic [1:0] txsel_reg;
	logic [1:0] rxsel_reg;
	logic [1:0] strap_cnt_reg;
	logic strap_done_reg;

	// address decode
	wire sel_data = bus_addr_i == ADDR_DATA;
	wire sel_high = bus_addr_i == ADDR_HIGH;
	wire sel_fifo = bus_addr_i == ADDR_FIFO;
	wire sel_line = bus_addr_i == ADDR_LINE;
	wire sel_modem = bus_addr_i == ADDR_MODEM;
	wire sel_feat = bus_addr_i == ADDR_FEAT;
	wire sel_enh = bus_addr_i == ADDR_ENH;
	wire sel_tx_trigger_level_reg = bus_addr_i == ADDR_TX_TRIGGER_LEVEL_REG;
	wire sel_rx_trigger_level_reg = bus_addr_i == ADDR_RX_TRIGGER_LEVEL_REG;
	wire sel_stat = bus_addr_i == ADDR_STAT;
	wire sel_level = bus_addr_i == ADDR_LEVEL;
	wire dlab = line_reg.dlab;
	wire thr_wr = bus_wr_i & sel_data & ~dlab;
	wire rhr_rd = bus_rd_i & sel_data & ~dlab;
	wire fcr_prog = bus_wr_i & sel_fifo & bus_wdata_i[FCR_EN];
	wire tx_clr = fcr_prog & bus_wdata_i[FCR_TXCLR];
	wire stat_rd = bus_rd_i & sel_stat;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			line_reg <= REG_RST;
			feat_reg <= REG_RST;
			enh_reg <= REG_RST;
			tx_trigger_level_reg_reg <= TRG_RST;
			rx_trigger_level_reg_reg <= TRG_RST;
			div_lo_reg <= DIV_LO_RST;
			div_hi_reg <= REG_RST;
		end else if (bus_wr_i) begin
			if (sel_line)
				line_reg <= bus_wdata_i;
			if (sel_feat)
				feat_reg <= bus_wdata_i;
			if (sel_enh)
				enh_reg <= bus_wdata_i;
			if (sel_tx_trigger_level_reg)
				tx_trigger_level_reg_reg <= bus_wdata_i;
			if (sel_rx_trigger_level_reg)
				rx_trigger_level_reg_reg <= bus_wdata_i;
			if (sel_data & dlab)
				div_lo_reg <= bus_wdata_i;
			if (sel_high & dlab)
				div_hi_reg <= bus_wdata_i;
		end
	end

	// fifo_control: a write without the enable bit only disables the fifos
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			fifo_en_reg <= 1'b0;
			dma_mode_reg <= 1'b0;
			txsel_reg <= 2'h0;
			rxsel_reg <= 2'h0;
		end else if (bus_wr_i & sel_fifo) begin
			fifo_en_reg <= bus_wdata_i[FCR_EN];
			if (fcr_prog) begin
				dma_mode_reg <= bus_wdata_i[FCR_DMA];
				txsel_reg <= bus_wdata_i[5:4];
				rxsel_reg <= bus_wdata_i[7:6];
			end
		end
	end

	// strap is taken once the synchroniser has settled after release
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			modem_reg <= REG_RST;
			strap_cnt_reg <= 2'h0;
			strap_done_reg <= 1'b0;
		end else if (~strap_done_reg) begin
			strap_cnt_reg <= strap_cnt_reg + 2'h1;
			if (strap_cnt_reg == STRAP_WAIT) begin
				// the filtered level lands on this same edge, so take it as it lands
				modem_reg.ir_en <= pin_f_nx[3];
				strap_done_reg <= 1'b1;
			end
		end else if (bus_wr_i & sel_modem) begin
			modem_reg <= bus_wdata_i & MODEM_WMASK;
		end
	end

	// trigger levels from the shared table
	wire [1:0] tbl = feat_reg[7:6];
	wire [7:0] rx_trig = (tbl == TBL_D) ? rx_trigger_level_reg_reg :
		(tbl == TBL_C) ? RX_TRIG_C[rxsel_reg] :
		(tbl == TBL_B) ? RX_TRIG_B[rxsel_reg] :
		RX_TRIG_A[rxsel_reg];
	wire [7:0] tx_trig = (tbl == TBL_D) ? tx_trigger_level_reg_reg :
		(tbl == TBL_C) ? TX_TRIG_C[txsel_reg] :
		(tbl == TBL_B) ? TX_TRIG_B[txsel_reg] :
		TX_TRIG_A;

	// half bit timebase
	wire [15:0] divisor = {div_hi_reg, div_lo_reg};
	logic [15:0] baud_cnt_reg;
	wire tick = baud_cnt_reg == 16'h0;
	wire [15:0] baud_load = (divisor == 16'h0) ? 16'h0 : divisor - 16'h1;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			baud_cnt_reg <= 16'h0;
		else
			baud_cnt_reg <= tick ? baud_load : baud_cnt_reg - 16'h1;
	end

	// character format
	wire [7:0] wmask = 8'hff >> (2'h3 - line_reg.wlen);
	wire [2:0] last_bit = {1'b1, line_reg.wlen};
	wire [2:0] stop_h = ~line_reg.stop ? STOP_H1 :
		(line_reg.wlen == 2'h0) ? STOP_H15 : STOP_H2;

	function automatic logic par_of(input logic [7:0] d, input ufc_line_s l);
		par_of = l.force_par ? ~l.even : (^d) ^ ~l.even;
	endfunction

	// fifos
	logic tx_valid;
	logic [7:0] tx_head;
	logic [CNT_W-1:0] tx_cnt;
	logic tx_in_ready;
	logic tx_go;
	logic rx_valid;
	logic rx_in_ready;
	logic rx_push;
	logic rx_accept;
	ufc_char_s rx_head;
	ufc_char_s rx_char;
	logic [CNT_W-1:0] rx_cnt;

	// without fifo mode each direction holds a single character
	wire tx_wr_ok = fifo_en_reg | ~tx_valid;
	assign rx_accept = rx_in_ready & (fifo_en_reg | ~rx_valid);

	ufc_fifo #(.W(8), .D(FIFO_D)) u_tx_fifo (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.clr_i(tx_clr),
		.in_valid_i(thr_wr & tx_wr_ok),
		.in_data_i(bus_wdata_i),
		.in_ready_o(tx_in_ready),
		.out_valid_o(tx_valid),
		.out_ready_i(tx_go),
		.out_data_o(tx_head),
		.count_o(tx_cnt)
	);

	ufc_fifo #(.W($bits(ufc_char_s)), .D(FIFO_D)) u_rx_fifo (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.clr_i(1'b0),
		.in_valid_i(rx_push & rx_accept),
		.in_data_i(rx_char),
		.in_ready_o(rx_in_ready),
		.out_valid_o(rx_valid),
		.out_ready_i(rhr_rd),
		.out_data_o(rx_head),
		.count_o(rx_cnt)
	);

	// transmitter
	ufc_bit_e tx_st_reg;
	ufc_bit_e tx_st_nx;
	logic [2:0] tx_h_nx;
	logic [7:0] tx_sh_reg;
	logic [2:0] tx_h_reg;
	logic [2:0] tx_n_reg;
	logic tx_par_reg;
	logic tx_halt_reg;
	wire pair = modem_reg.pair_sel;
	wire cts_block = enh_reg[EFR_ACTS] &
		(pair ? pin_f_reg[2] : pin_f_reg[1]);
	wire tx_end = tick & (tx_h_reg == 3'h1);
	// starting only on a tick keeps the start bit whole; a waiting character
	// follows the stop bit with no idle gap
	wire tx_free = (tx_st_reg == BIT_IDLE) |
		((tx_st_reg == BIT_STOP) & tx_end);
	// flow control only stops between characters, never mid frame
	assign tx_go = tx_free & tick & tx_valid & ~cts_block & ~tx_halt_reg;

	always_comb begin
		tx_st_nx = BIT_IDLE;
		tx_h_nx = HALF_BIT;
		case (tx_st_reg)
			BIT_START: tx_st_nx = BIT_DATA;
			BIT_DATA: begin
				if (tx_n_reg != last_bit) begin
					tx_st_nx = BIT_DATA;
				end else if (line_reg.pen) begin
					tx_st_nx = BIT_PAR;
				end else begin
					tx_st_nx = BIT_STOP;
					tx_h_nx = stop_h;
				end
			end
			BIT_PAR: begin
				tx_st_nx = BIT_STOP;
				tx_h_nx = stop_h;
			end
			default: tx_st_nx = BIT_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_st_reg <= BIT_IDLE;
			tx_sh_reg <= 8'h00;
			tx_h_reg <= HALF_BIT;
			tx_n_reg <= 3'h0;
			tx_par_reg <= 1'b0;
		end else if (tx_go) begin
			tx_st_reg <= BIT_START;
			tx_sh_reg <= tx_head;
			tx_par_reg <= par_of(tx_head & wmask, line_reg);
			tx_h_reg <= HALF_BIT;
		end else if (tx_end) begin
			tx_st_reg <= tx_st_nx;
			tx_h_reg <= tx_h_nx;
			tx_n_reg <= (tx_st_reg == BIT_DATA) ? tx_n_reg + 3'h1 : 3'h0;
			if (tx_st_reg == BIT_DATA)
				tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
		end else if (tick & (tx_st_reg != BIT_IDLE)) begin
			tx_h_reg <= tx_h_reg - 3'h1;
		end
	end

	wire tx_line = (tx_st_reg == BIT_DATA) ? tx_sh_reg[0] :
		(tx_st_reg == BIT_PAR) ? tx_par_reg :
		(tx_st_reg != BIT_START);
	wire line_eff = tx_line & ~line_reg.brk;
	wire ir_en = modem_reg.ir_en;
	// infrared pulse fills the first half of each space bit
	wire ir_enc = ~line_eff & tx_h_reg[1];
	wire loop_en = modem_reg.loop_en;
	wire tx_pin_nx = loop_en ? ~ir_en : (ir_en ? ir_enc : line_eff);

	// infrared decoder: a pulse marks the rest of the bit as space
	logic [1:0] ir_hold_reg;
	wire ir_in = pin_f_reg[0] ^ feat_reg[FEATURE_CONTROL_IRINV];
	wire ir_dec = (ir_hold_reg == 2'h0) & ~ir_in;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			ir_hold_reg <= 2'h0;
		else if (ir_in)
			ir_hold_reg <= 2'h2;
		else if (tick & (ir_hold_reg != 2'h0))
			ir_hold_reg <= ir_hold_reg - 2'h1;
	end

	wire rx_src = loop_en ? line_eff : (ir_en ? ir_dec : pin_f_reg[0]);

	// receiver samples mid-bit on half bit ticks
	ufc_bit_e rx_st_reg;
	ufc_bit_e rx_st_nx;
	logic [7:0] rx_sh_reg;
	logic [2:0] rx_n_reg;
	logic rx_h_reg;
	logic rx_par_reg;
	wire rx_smp = tick & rx_h_reg;

	always_comb begin
		rx_st_nx = BIT_IDLE;
		case (rx_st_reg)
			BIT_IDLE: rx_st_nx = rx_src ? BIT_IDLE : BIT_START;
			BIT_START: rx_st_nx = rx_src ? BIT_IDLE : BIT_DATA;
			BIT_DATA: begin
				if (rx_n_reg != last_bit)
					rx_st_nx = BIT_DATA;
				else
					rx_st_nx = line_reg.pen ? BIT_PAR : BIT_STOP;
			end
			BIT_PAR: rx_st_nx = BIT_STOP;
			default: rx_st_nx = BIT_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_st_reg <= BIT_IDLE;
			rx_sh_reg <= 8'h00;
			rx_n_reg <= 3'h0;
			rx_h_reg <= 1'b0;
			rx_par_reg <= 1'b0;
		end else if (tick & (rx_st_reg == BIT_IDLE)) begin
			rx_st_reg <= rx_st_nx;
			rx_h_reg <= 1'b1;
		end else if (tick) begin
			rx_h_reg <= ~rx_h_reg;
			if (rx_h_reg) begin
				rx_st_reg <= rx_st_nx;
				rx_n_reg <= (rx_st_reg == BIT_DATA) ? rx_n_reg + 3'h1 : 3'h0;
				if (rx_st_reg == BIT_DATA)
					rx_sh_reg <= {rx_src, rx_sh_reg[7:1]};
				if (rx_st_reg == BIT_PAR)
					rx_par_reg <= rx_src;
			end
		end
	end

	wire [7:0] rx_data = rx_sh_reg >> (2'h3 - line_reg.wlen);
	wire rx_perr = line_reg.pen & (rx_par_reg != par_of(rx_data, line_reg));
	assign rx_push = rx_smp & (rx_st_reg == BIT_STOP);
	assign rx_char = {~rx_src, rx_perr, rx_data};

	// sticky status, a new event beats the clearing read
	logic perr_reg;
	logic ferr_reg;
	logic ovr_reg;
	wire rx_got = rx_push & rx_accept;
	wire sw_flow = enh_reg[EFR_SWFLOW];

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			perr_reg <= 1'b0;
			ferr_reg <= 1'b0;
			ovr_reg <= 1'b0;
			tx_halt_reg <= 1'b0;
		end else begin
			perr_reg <= (perr_reg & ~stat_rd) | (rx_got & rx_perr);
			ferr_reg <= (ferr_reg & ~stat_rd) | (rx_got & ~rx_src);
			ovr_reg <= (ovr_reg & ~stat_rd) | (rx_push & ~rx_accept);
			if (~sw_flow)
				tx_halt_reg <= 1'b0;
			else if (rx_got & (rx_data == XOFF_CHAR))
				tx_halt_reg <= 1'b1;
			else if (rx_got & ((rx_data == XON_CHAR) | modem_reg.xon_any))
				tx_halt_reg <= 1'b0;
		end
	end

	// interrupt levels
	wire [7:0] tx_lvl = {5'h00, tx_cnt};
	wire [7:0] rx_lvl = {5'h00, rx_cnt};
	logic tx_above_reg;
	wire tx_irq_nx = tx_above_reg ? (tx_lvl < tx_trig) : (tx_cnt == '0);
	wire rx_irq_nx = rx_valid & (rx_lvl >= rx_trig);

	// modem outputs, auto flow drops the selected line while rx is full
	wire auto_rts = enh_reg[EFR_ARTS];
	wire rx_stop = auto_rts & ~rx_in_ready;
	wire rts_n_nx = loop_en | ~modem_reg.rts | (rx_stop & ~pair);
	wire dtr_n_nx = loop_en | ~modem_reg.dtr | (rx_stop & pair);

	// read mux
	wire [7:0] stat_val = {dma_mode_reg, ovr_reg, tx_halt_reg, ferr_reg,
		perr_reg, ~tx_in_ready, ~tx_valid, rx_valid};
	wire [7:0] rd_mux = sel_data ? (dlab ? div_lo_reg : rx_head.data) :
		sel_high ? (dlab ? div_hi_reg : 8'h00) :
		sel_fifo ? {fifo_en_reg, fifo_en_reg, ISR_NONE} :
		sel_line ? line_reg :
		sel_modem ? modem_reg :
		sel_feat ? feat_reg :
		sel_enh ? enh_reg :
		sel_tx_trigger_level_reg ? tx_trigger_level_reg_reg :
		sel_rx_trigger_level_reg ? rx_trigger_level_reg_reg :
		sel_stat ? stat_val :
		sel_level ? {1'b0, rx_cnt, 1'b0, tx_cnt} :
		8'h00;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_rdata_o <= 8'h00;
			tx_o <= OUT_IDLE;
			rts_n_o <= OUT_IDLE;
			dtr_n_o <= OUT_IDLE;
			tx_irq_o <= 1'b0;
			rx_irq_o <= 1'b0;
			tx_above_reg <= 1'b0;
		end else begin
			if (bus_rd_i)
				bus_rdata_o <= rd_mux;
			tx_o <= tx_pin_nx;
			rts_n_o <= rts_n_nx;
			dtr_n_o <= dtr_n_nx;
			tx_irq_o <= tx_irq_nx;
			rx_irq_o <= rx_irq_nx;
			if (tx_cnt == '0)
				tx_above_reg <= 1'b0;
			else if (tx_lvl > tx_trig)
				tx_above_reg <= 1'b1;
		end
	end
endmodule

// file: bench/ufc_core_props.sv
// Purpose: port-level checks for the uart control block
// Assumes: only ufc_core ports are visible
// Notes: line and modem registers are shadowed from host writes
`timescale 1ns/1ps
module ufc_core_props
	import ufc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [3:0] bus_addr_i,
	input wire logic [7:0] bus_wdata_i,
	input wire logic [7:0] bus_rdata_o,
	input wire logic tx_o,
	input wire logic dtr_n_o,
	input wire logic rts_n_o,
	input wire logic tx_irq_o,
	input wire logic rx_irq_o
);
	ufc_line_s line_reg;
	ufc_modem_s modem_reg;
	logic flow_reg;
	logic [2:0] wr_hist_reg;
	logic quiet;
	logic unmapped;
	// the break, modem and loopback checks only judge outputs once recent writes have had time to land
	assign quiet = (wr_hist_reg == 3'h0) && !bus_wr_i;
	assign unmapped = bus_addr_i inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			line_reg <= '0;
			modem_reg <= '0;
			flow_reg <= 1'b0;
			wr_hist_reg <= 3'h0;
		end else begin
			wr_hist_reg <= {wr_hist_reg[1:0], bus_wr_i};
			if (bus_wr_i && bus_addr_i == ADDR_LINE)
				line_reg <= bus_wdata_i;
			if (bus_wr_i && bus_addr_i == ADDR_MODEM)
				modem_reg <= bus_wdata_i & MODEM_WMASK;
			if (bus_wr_i && bus_addr_i == ADDR_ENH)
				flow_reg <= bus_wdata_i[EFR_ARTS];
		end
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	rst_vals_a: assert property ($fell(rst_i) |->
		tx_o && rts_n_o && dtr_n_o && !rx_irq_o && bus_rdata_o == 8'h00)
		else $error("outputs not at reset values");
	rd_zero_a: assert property (bus_rd_i && unmapped |=>
		bus_rdata_o == 8'h00) else $error("unmapped read not zero");
	rsvd_bit_a: assert property (bus_rd_i && bus_addr_i == ADDR_MODEM |=>
		!bus_rdata_o[3]) else $error("reserved modem bit set");
	fifo_rd_a: assert property (bus_rd_i && bus_addr_i == ADDR_FIFO |=>
		bus_rdata_o[5:0] == 6'h01 && bus_rdata_o[7] == bus_rdata_o[6])
		else $error("fifo control readback wrong");
	line_back_a: assert property (bus_rd_i && bus_addr_i == ADDR_LINE |=>
		bus_rdata_o == $past(line_reg)) else $error("line readback wrong");
	brk_hold_a: assert property (quiet && line_reg.brk &&
		!modem_reg.loop_en && !modem_reg.ir_en |-> !tx_o)
		else $error("break not holding tx low");
	dtr_inv_a: assert property (quiet && !modem_reg.loop_en && !flow_reg |->
		dtr_n_o == !modem_reg.dtr && rts_n_o == !modem_reg.rts)
		else $error("modem outputs not inverted");
	loop_idle_a: assert property (quiet && modem_reg.loop_en &&
		!modem_reg.ir_en |-> tx_o && rts_n_o && dtr_n_o)
		else $error("pins active in loopback");
	txclr_irq_a: assert property (bus_wr_i && bus_addr_i == ADDR_FIFO &&
		bus_wdata_i[FCR_EN] && bus_wdata_i[FCR_TXCLR] |-> ##[1:3] tx_irq_o)
		else $error("no tx interrupt after tx fifo clear");
	cover property (bus_wr_i && bus_addr_i == ADDR_FIFO && bus_wdata_i[2]);
	cover property (rx_irq_o);
	cover property (quiet && line_reg.brk && !tx_o);
endmodule
bind ufc_core ufc_core_props chk_u (.mclk_i, .rst_i, .bus_wr_i, .bus_rd_i,
	.bus_addr_i, .bus_wdata_i, .bus_rdata_o, .tx_o, .dtr_n_o, .rts_n_o,
	.tx_irq_o, .rx_irq_o);

// file: bench/ufc_remote.sv
// Purpose: remote serial device on the tx and rx lines
// Assumes: one bit lasts BITC clocks
// Notes: samples nbits_i bits after each start, first stop included
`timescale 1ns/1ps
module ufc_remote #(
	parameter int BITC = 8
) (
	input wire logic mclk_i,
	input wire logic tx_i,
	input wire logic [3:0] nbits_i,
	output logic rx_o,
	output logic [11:0] frame_o,
	output int frames_o,
	output int gap_o
);
	int now = 0;
	int last;
	always @(posedge mclk_i) now <= now + 1;
	initial begin
		rx_o = 1'b1;
		frames_o = 0;
		gap_o = 0;
		last = 0;
		forever begin
			@(negedge tx_i);
			gap_o = now - last;
			last = now;
			frame_o = '0;
			repeat (BITC / 2) @(posedge mclk_i);
			for (int i = 0; i < nbits_i; i++) begin
				repeat (BITC) @(posedge mclk_i);
				frame_o[i] = tx_i;
			end
			frames_o++;
		end
	end
	// f holds data, parity and stop, lsb first
	task automatic send(input logic [11:0] f, input int n);
		@(posedge mclk_i);
		#1 rx_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			repeat (BITC) @(posedge mclk_i);
			#1 rx_o = f[i];
		end
		repeat (BITC) @(posedge mclk_i);
	endtask
endmodule

// file: bench/ufc_core_tb.sv
// Purpose: self-checking bench for the uart control block
// Assumes: divisor 4, so one bit is 8 clocks
// Notes: the remote model decodes every frame on tx_o
`timescale 1ns/1ps
module ufc_core_tb
	import ufc_pkg::*;
;
	localparam int BITC = 8;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [3:0] bus_addr = 4'h0;
	logic [7:0] bus_wdata = 8'h00;
	logic strap = 1'b1;
	logic cts_n = 1'b0;
	logic dsr_n = 1'b0;
	logic [3:0] nb = 4'h9;
	logic [7:0] rdata;
	logic [11:0] frame;
	logic rx, tx, dtr_n, rts_n, tx_irq, rx_irq;
	int frm, gap;
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	ufc_core dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .bus_wr_i(bus_wr),
		.bus_rd_i(bus_rd), .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata),
		.bus_rdata_o(rdata), .rx_i(rx), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
		.infrared_select_pin_i(strap), .tx_o(tx), .dtr_n_o(dtr_n),
		.rts_n_o(rts_n), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
	ufc_remote #(.BITC(BITC)) rem_u (.mclk_i(mclk_i), .tx_i(tx),
		.nbits_i(nb), .rx_o(rx), .frame_o(frame), .frames_o(frm),
		.gap_o(gap));
	initial forever #20 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		#1 bus_wr = 1'b1;
		bus_addr = a;
		bus_wdata = d;
		@(posedge mclk_i);
		#1 bus_wr = 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		#1 bus_rd = 1'b1;
		bus_addr = a;
		@(posedge mclk_i);
		#1 bus_rd = 1'b0;
		chk(rdata, e);
	endtask
	task automatic wait_frame(input int n);
		for (int i = 0; i < 1000 && frm != n; i++) @(negedge mclk_i);
		chk(frm, n);
		repeat (2 * BITC) @(negedge mclk_i);
	endtask
	function automatic logic [11:0] fexp(input logic [7:0] lc,
		input logic [7:0] c);
		int n;
		logic [11:0] f;
		n = 5 + int'(lc[1:0]);
		f = 12'(c & ~(8'hff << n));
		f[n] = lc[3] ? (lc[5] ? !lc[4] : ^f ^ !lc[4]) : 1'b1;
		f[n + 1] = lc[3];
		return f;
	endfunction
	task automatic t_reset();
		chk({dtr_n, rts_n}, 2'b11);
		rdc(ADDR_MODEM, 8'h40);
		rdc(ADDR_LINE, 8'h00);
		wr(ADDR_MODEM, 8'h2b);
		rdc(ADDR_MODEM, 8'h23);
		chk({dtr_n, rts_n}, 2'b00);
		wr(ADDR_MODEM, 8'h00);
		repeat (3) @(posedge mclk_i);
		#1 chk({dtr_n, rts_n, tx}, 3'b111);
		repeat (80) @(posedge mclk_i);
	endtask
	task automatic t_div();
		wr(ADDR_LINE, 8'h80);
		wr(ADDR_DATA, 8'h04);
		// a small high byte keeps a reload of the timebase short
		wr(ADDR_HIGH, 8'h01);
		rdc(ADDR_DATA, 8'h04);
		rdc(ADDR_HIGH, 8'h01);
		wr(ADDR_HIGH, 8'h00);
		wr(ADDR_LINE, 8'h03);
		rdc(ADDR_HIGH, 8'h00);
		rdc(ADDR_LEVEL, 8'h00);
		rdc(4'h5, 8'h00);
	endtask
	task automatic t_format();
		logic [7:0] cfg [6] = '{8'h00, 8'h09, 8'h1a, 8'h2b, 8'h3b, 8'h1b};
		int n0;
		wr(ADDR_FIFO, 8'h01);
		rdc(ADDR_FIFO, 8'hc1);
		foreach (cfg[i]) begin
			wr(ADDR_LINE, cfg[i]);
			nb = 4'(6 + cfg[i][1:0] + cfg[i][3]);
			n0 = frm;
			wr(ADDR_DATA, 8'hb4 + 8'(i));
			wait_frame(n0 + 1);
			chk(frame, fexp(cfg[i], 8'hb4 + 8'(i)));
		end
	endtask
	task automatic t_stop();
		logic [7:0] cfg [3] = '{8'h03, 8'h04, 8'h07};
		int ticks [3] = '{2, 3, 4};
		int n0, g;
		foreach (cfg[i]) begin
			wr(ADDR_LINE, cfg[i]);
			nb = 4'(6 + cfg[i][1:0]);
			n0 = frm;
			wr(ADDR_DATA, 8'h55);
			wr(ADDR_DATA, 8'haa);
			wait_frame(n0 + 2);
			g = BITC * (6 + cfg[i][1:0]) + ticks[i] * BITC / 2;
			chk(gap >= g && gap <= g + 2, 1'b1);
		end
	endtask
	task automatic t_break();
		wr(ADDR_LINE, 8'h43);
		repeat (2) @(posedge mclk_i);
		repeat (20) begin
			@(posedge mclk_i);
			#1 chk(tx, 1'b0);
		end
		wr(ADDR_LINE, 8'h03);
		repeat (3) @(posedge mclk_i);
		#1 chk(tx, 1'b1);
		repeat (100) @(posedge mclk_i);
	endtask
	task automatic t_txclr();
		int n0;
		n0 = frm;
		wr(ADDR_DATA, 8'h31);
		wr(ADDR_DATA, 8'h32);
		wr(ADDR_DATA, 8'h33);
		repeat (2) @(negedge mclk_i);
		chk(tx_irq, 1'b0);
		wr(ADDR_FIFO, 8'h05);
		rdc(ADDR_LEVEL, 8'h00);
		chk(tx_irq, 1'b1);
		wait_frame(n0 + 1);
		chk(frame, fexp(8'h03, 8'h31));
		repeat (150) @(posedge mclk_i);
		chk(frm, n0 + 1);
	endtask
	task automatic t_rxtrig();
		int k;
		wr(ADDR_FIFO, 8'h41);
		wr(ADDR_RX_TRIGGER_LEVEL_REG, 8'h02);
		for (int p = 0; p < 2; p++) begin
			k = p ? 2 : 4;
			for (int j = 0; j < k; j++) begin
				chk(rx_irq, 1'b0);
				rem_u.send({4'hf, 8'h40 + 8'(j)}, 9);
				// push lands up to four clocks after the stop bit ends, rx_irq one clock later
				repeat (8) @(negedge mclk_i);
			end
			chk(rx_irq, 1'b1);
			for (int j = 0; j < k; j++) rdc(ADDR_DATA, 8'h40 + 8'(j));
			wr(ADDR_FEAT, 8'hc0);
		end
		chk(rx_irq, 1'b0);
		wr(ADDR_FEAT, 8'h00);
		wr(ADDR_FIFO, 8'h01);
	endtask
	task automatic t_loop();
		int n0;
		n0 = frm;
		wr(ADDR_MODEM, 8'h13);
		wr(ADDR_DATA, 8'h5c);
		repeat (120) @(negedge mclk_i);
		chk({tx, rts_n, dtr_n}, 3'b111);
		chk(frm, n0);
		chk(rx_irq, 1'b1);
		rdc(ADDR_DATA, 8'h5c);
		wr(ADDR_MODEM, 8'h00);
	endtask
	initial begin
		repeat (12) @(posedge mclk_i);
		#1 rst_i = 1'b0;
		// inverted infrared input keeps the idle rx line from reading as
		// a pulse while the strap still has infrared mode on
		wr(ADDR_FEAT, 8'h10);
		repeat (6) @(posedge mclk_i);
		#1 t_reset();
		t_div();
		t_format();
		t_stop();
		t_break();
		t_txclr();
		t_rxtrig();
		t_loop();
		wrap_up();
	end
endmodule
